// ### fault_source_model.sv
`timescale 1ns/10ps
module fault_source_model
    import led_regs_pkg::*;
(
    input  wire logic         core_clk_in,
    input  wire logic         fire_in,
    input  wire fault_flags_s pattern_in,
    output logic [7:0]        open_det_out,
    output logic [7:0]        short_det_out,
    output logic              thermal_det_out,
    output logic              cmd_err_out
);
    logic [2:0]   hold_q = 3'h0;
    fault_flags_s pat_q  = '0;
    // Levels held long enough to pass the two-flop sync
    always_ff @(posedge core_clk_in) begin
        if (fire_in) begin
            pat_q  <= pattern_in;
            hold_q <= 3'h4;
        end else if (hold_q != 3'h0) begin
            hold_q <= hold_q - 3'h1;
        end
    end
    assign open_det_out    = (hold_q != 3'h0) ? pat_q.led_open : 8'h00;
    assign short_det_out   = (hold_q != 3'h0) ? pat_q.led_short : 8'h00;
    assign thermal_det_out = (hold_q != 3'h0) && pat_q.thermal;
    // Serial command error is a single-cycle event
    assign cmd_err_out     = fire_in && pattern_in.cmd_err;
endmodule // fault_source_model

// ### led_driver_config_fault_regs.sv
`timescale 1ns/10ps
`include "led_regs_cfg.svh"

// How it works
// - Diagnostics bits 23..16 high put each paired pin in LED diagnostics mode.
// - Config bits 15..0 each enable one output power switch when high.
// - Odd output bit drives the switch of its whole diagnostics pin pair.
// - Even output bit drives only its own single output switch.
// - Fault readback sits at offset 1 and resets to zero.
// - Pair open flag sets on open LED, clears when read.
// - Pair short flag sets on shorted LED, clears when read.
// - Flags packed per pair descending, open above short.
// - Bit 7 flags thermal shutdown, clears when read.
// - Bit 6 flags command error of last transfer, clears when read.
// - Bits 5..0 read the configuration checksum.
module led_driver_config_fault_regs
    import led_regs_pkg::*;
(
    input  wire logic       core_clk_in,
    input  wire logic       resetn_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic       reg_addr_in,
    input  wire reg_word_t  reg_wdata_in,
    output reg_word_t       reg_rdata_out,
    output logic            reg_rvalid_out,
    input  wire logic [7:0] led_open_det_in,
    input  wire logic [7:0] led_short_det_in,
    input  wire logic       thermal_det_in,
    input  wire logic       cmd_err_in,
    input  wire crc_t       crc_in,
    output logic [15:0]     drain_switch_out,
    output logic [7:0]      pair_switch_out,
    output logic [7:0]      diag_mode_out
);

    reg_word_t    cfg_q;
    reg_word_t    cfg_d;
    reg_word_t    rdata_q;
    reg_word_t    rdata_d;
    logic         rvalid_q;
    logic         rvalid_d;
    logic [16:0]  det_meta_q;
    logic [16:0]  det_sync_q;
    fault_flags_s set_flags;
    fault_flags_s clr_flags;
    fault_flags_s flags;
    reg_word_t    fault_word;
    logic         wr_config;
    logic         rd_fault;

    function automatic logic hits(input logic strobe, input logic addr, input logic offs);
        hits = strobe && (addr == offs);
    endfunction

    assign wr_config = hits(reg_wr_in, reg_addr_in, `CONFIG_OFFSET);
    assign rd_fault  = hits(reg_rd_in, reg_addr_in, `FAULT_OFFSET);

    // Analog detector levels are asynchronous to the core clock
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            det_meta_q <= 17'h00000;
            det_sync_q <= 17'h00000;
        end else begin
            det_meta_q <= {led_open_det_in, led_short_det_in, thermal_det_in};
            det_sync_q <= det_meta_q;
        end
    end

    always_comb begin
        set_flags.led_open  = det_sync_q[16:9];
        set_flags.led_short = det_sync_q[8:1];
        set_flags.thermal   = det_sync_q[0];
        set_flags.cmd_err   = cmd_err_in;
        // Clear exactly what the read captured
        clr_flags = rd_fault ? flags : '0;
    end

    rc_flag_bank u_flags (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .set_in      (set_flags),
        .clr_in      (clr_flags),
        .flags_out   (flags)
    );

    // Readback layout, pair 7 on top, open above short
    generate
        for (genvar k = 0; k < 8; k++) begin : g_pack
            assign fault_word[`PAIR_FLAGS_LSB + 2*k + 1] = flags.led_open[k];
            assign fault_word[`PAIR_FLAGS_LSB + 2*k]     = flags.led_short[k];
        end
    endgenerate
    assign fault_word[`THERMAL_BIT]   = flags.thermal;
    assign fault_word[`CMD_ERR_BIT]   = flags.cmd_err;
    assign fault_word[`CRC_MSB:0]     = crc_in;

    always_comb begin
        cfg_d    = cfg_q;
        rdata_d  = rdata_q;
        rvalid_d = reg_rd_in;
        if (wr_config) begin
            cfg_d = reg_wdata_in;
        end
        // Configuration never reads back
        if (reg_rd_in) begin
            rdata_d = rd_fault ? fault_word : `CONFIG_RESET;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            cfg_q    <= `CONFIG_RESET;
            rdata_q  <= `FAULT_RESET;
            rvalid_q <= 1'b0;
        end else begin
            cfg_q    <= cfg_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_rdata_out  = rdata_q;
    assign reg_rvalid_out = rvalid_q;

    assign drain_switch_out = cfg_q[`DRAIN_CFG_MSB:0];
    assign diag_mode_out    = cfg_q[`DIAG_CFG_MSB:`DIAG_CFG_LSB];
    generate
        for (genvar k = 0; k < 8; k++) begin : g_pair
            assign pair_switch_out[k] = cfg_q[2*k + 1];
        end
    endgenerate

    sequence config_write_s;
        wr_config;
    endsequence

    sequence fault_read_s;
        rd_fault;
    endsequence

    sequence quiet_set_s;
        set_flags == '0;
    endsequence

    diag_mode_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        config_write_s |=> (diag_mode_out == $past(reg_wdata_in[23:16])))
        else $error("diagnostics mode not taken from write");

    drain_switch_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        config_write_s |=> (drain_switch_out == $past(reg_wdata_in[15:0])))
        else $error("output switches not taken from write");

    pair_switch_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        config_write_s |=> (pair_switch_out[7] == $past(reg_wdata_in[15]))
            && (pair_switch_out[0] == $past(reg_wdata_in[1])))
        else $error("pair switch not governed by odd bit");

    single_switch_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        config_write_s ##0 (reg_wdata_in[14] != reg_wdata_in[15])
            |=> (drain_switch_out[14] != pair_switch_out[7]))
        else $error("even bit leaks into pair switch");

    fault_layout_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        fault_read_s |=> reg_rvalid_out
            && (reg_rdata_out[23] == $past(flags.led_open[7]))
            && (reg_rdata_out[22] == $past(flags.led_short[7]))
            && (reg_rdata_out[9:8] == {$past(flags.led_open[0]), $past(flags.led_short[0])}))
        else $error("fault pair layout wrong");

    status_bits_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        fault_read_s |=> (reg_rdata_out[7:6] == {$past(flags.thermal), $past(flags.cmd_err)}))
        else $error("thermal or command error bit wrong");

    crc_field_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        fault_read_s |=> (reg_rdata_out[5:0] == $past(crc_in)))
        else $error("checksum field wrong");

    read_clear_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        fault_read_s ##0 quiet_set_s ##1 quiet_set_s |-> (flags == '0) [*2])
        else $error("flags not cleared by read");

    config_hidden_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        reg_rd_in && (reg_addr_in == `CONFIG_OFFSET) |=> reg_rvalid_out && (reg_rdata_out == '0))
        else $error("configuration readable");

    reset_zero_a: assert property (@(posedge core_clk_in)
        !resetn_in |=> (cfg_q == '0) && (flags == '0) && !reg_rvalid_out
            && (reg_rdata_out == '0))
        else $error("reset values not zero");

    rvalid_idle_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        !reg_rd_in |=> !reg_rvalid_out)
        else $error("read valid without a read");

    rdata_hold_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        !reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data changed without a read");

    config_hold_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        !wr_config |=> $stable(cfg_q))
        else $error("configuration changed without a write");

    read_keeps_set_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        fault_read_s |=> ((flags & $past(set_flags)) == $past(set_flags)))
        else $error("fault during read lost");

    fault_write_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        reg_wr_in && (reg_addr_in == `FAULT_OFFSET) && !reg_rd_in ##0 quiet_set_s
            |=> (flags == $past(flags)))
        else $error("write altered fault flags");

    thermal_level_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        det_sync_q[0] |=> flags.thermal)
        else $error("thermal flag not set");

    cmd_err_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        cmd_err_in |=> flags.cmd_err)
        else $error("command error flag not set");

    open_sets_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (det_sync_q[16:9] != 8'h00)
            |=> ((flags.led_open & $past(det_sync_q[16:9])) == $past(det_sync_q[16:9])))
        else $error("open flag not set by detector");

    short_sets_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (det_sync_q[8:1] != 8'h00)
            |=> ((flags.led_short & $past(det_sync_q[8:1])) == $past(det_sync_q[8:1])))
        else $error("short flag not set by detector");

endmodule // led_driver_config_fault_regs

// ### led_driver_config_fault_regs_bench.sv
`timescale 1ns/10ps
module led_driver_config_fault_regs_bench
    import led_regs_pkg::*;
;
    logic         clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, addr = 1'b0, fire = 1'b0;
    reg_word_t    wdata = '0, rdata, w;
    logic         rvalid, thermal, cmd_err;
    logic [7:0]   open_det, short_det, pair_sw, diag;
    logic [15:0]  drain;
    crc_t         crc = '0;
    fault_flags_s pat = '0;
    int           n_mismatch = 0, n_checks = 0, cycles = 0;

    always #2.5 clk = ~clk;

    led_driver_config_fault_regs u_led_driver_config_fault_regs (
        .core_clk_in(clk), .resetn_in(rstn), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid), .led_open_det_in(open_det), .led_short_det_in(short_det),
        .thermal_det_in(thermal), .cmd_err_in(cmd_err), .crc_in(crc),
        .drain_switch_out(drain), .pair_switch_out(pair_sw), .diag_mode_out(diag));

    fault_source_model u_fault_source_model (
        .core_clk_in(clk), .fire_in(fire), .pattern_in(pat), .open_det_out(open_det),
        .short_det_out(short_det), .thermal_det_out(thermal), .cmd_err_out(cmd_err));

    function automatic reg_word_t exp_fault(fault_flags_s f, crc_t c);
        reg_word_t e;
        e = {16'h0000, f.thermal, f.cmd_err, c};
        for (int k = 0; k < 8; k++) begin
            e[9+2*k] = f.led_open[k];
            e[8+2*k] = f.led_short[k];
        end
        return e;
    endfunction

    function automatic reg_word_t exp_pair(reg_word_t v);
        reg_word_t p;
        p = '0;
        for (int k = 0; k < 8; k++) p[k] = v[2*k+1];
        return p;
    endfunction

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input reg_word_t got, input reg_word_t exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic a, input reg_word_t d);
        @(posedge clk);
        #1;
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1;
        wr = 1'b0;
    endtask

    task automatic rd_chk(input logic a, input reg_word_t e, input logic f);
        @(posedge clk);
        #1;
        rd = 1'b1;
        addr = a;
        fire = f;
        @(posedge clk);
        #1;
        rd = 1'b0;
        fire = 1'b0;
        chk({23'h0, rvalid}, 24'h000001);
        chk(rdata, e);
        @(posedge clk);
        #1;
        chk({23'h0, rvalid}, 24'h000000);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            conclude();
        end
    end

    initial begin
        void'($urandom(25783));
        for (int r = 0; r < 2; r++) begin
            repeat (5) @(posedge clk);
            #1 rstn = 1'b1;
            chk({diag, drain}, 24'h000000);
            chk({16'h0000, pair_sw}, 24'h000000);
            chk(rdata, 24'h000000);
            rd_chk(1'h1, 24'h000000, 1'b0);
            for (int i = 0; i < 6; i++) begin
                w = (i == 0) ? 24'hffffff : (i == 1) ? 24'h000000 : reg_word_t'($urandom);
                wr_reg(1'h0, w);
                chk({diag, drain}, w);
                chk({16'h0000, pair_sw}, exp_pair(w));
                rd_chk(1'h0, 24'h000000, 1'b0);
            end
            wr_reg(1'h1, 24'hffffff);
            chk({diag, drain}, w);
            for (int i = 0; i < 4; i++) begin
                pat = (i == 0) ? '1 : fault_flags_s'($urandom);
                crc = crc_t'($urandom);
                rd_chk(1'h1, exp_fault('0, crc), 1'b1);
                repeat (10) @(posedge clk);
                rd_chk(1'h1, exp_fault(pat, crc), 1'b0);
                rd_chk(1'h1, exp_fault('0, crc), 1'b0);
            end
            wr_reg(1'h0, 24'habcdef);
            pat = '1;
            fire = 1'b1;
            @(posedge clk);
            #1 fire = 1'b0;
            rstn = 1'b0;
            crc = '0;
        end
        conclude();
    end
endmodule // led_driver_config_fault_regs_bench

// ### led_regs_cfg.svh
`ifndef LED_REGS_CFG_SVH
`define LED_REGS_CFG_SVH

// Register offsets on the register port
`define CONFIG_OFFSET    1'h0
`define FAULT_OFFSET     1'h1

// Reset values
`define CONFIG_RESET     24'h000000
`define FAULT_RESET      24'h000000
`define FLAGS_RESET      18'h00000

// Field positions
`define DIAG_CFG_LSB     16
`define DIAG_CFG_MSB     23
`define DRAIN_CFG_MSB    15
`define PAIR_FLAGS_LSB   8
`define THERMAL_BIT      7
`define CMD_ERR_BIT      6
`define CRC_MSB          5

`endif

// ### led_regs_pkg.sv
package led_regs_pkg;

    typedef logic [23:0] reg_word_t;
    typedef logic [5:0]  crc_t;

    // Per-pair fault flags, pair 7 in the top bit
    typedef struct packed {
        logic [7:0] led_open;
        logic [7:0] led_short;
        logic       thermal;
        logic       cmd_err;
    } fault_flags_s;

endpackage

// ### rc_flag_bank.sv
`timescale 1ns/10ps
`include "led_regs_cfg.svh"

module rc_flag_bank
    import led_regs_pkg::*;
(
    input  wire logic         core_clk_in,
    input  wire logic         resetn_in,
    input  wire fault_flags_s set_in,
    input  wire fault_flags_s clr_in,
    output fault_flags_s      flags_out
);

    fault_flags_s flags_q;
    fault_flags_s flags_d;

    // Set wins over a clear in the same cycle
    always_comb begin
        flags_d = (flags_q & ~clr_in) | set_in;
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            flags_q <= `FLAGS_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags_out = flags_q;

    set_wins_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (set_in != '0) |=> ((flags_q & $past(set_in)) == $past(set_in)))
        else $error("flag lost while being set");

    clear_only_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clr_in != '0) && (set_in == '0) |=> ((flags_q & $past(clr_in)) == '0))
        else $error("read flag not cleared");

    sticky_a: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clr_in == '0) |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
        else $error("flag dropped without a read");

endmodule // rc_flag_bank
